/* File: core/adc_window_and_result_control.sv */
// Operation
// RQ1 - Window mode code picks the match condition
// RQ2 - Compare full 16-bit result with thresholds
// RQ3 - Sample length adds cycles to two
// RQ4 - Selector codes: pins 0-11, reference, ground
// RQ5 - Selector change waits for conversion end
// RQ6 - Writing command bit one starts conversion
// RQ7 - Command bit reads one while busy
// RQ8 - Enabled start event starts a conversion
// RQ9 - Interrupt needs both flag and enable
// RQ10 - Window flag sets on matching finished result
// RQ11 - Window flag clears by one or read
// RQ12 - Result flag sets when result arrives
// RQ13 - Result flag clears by one or read
// RQ14 - Debug halt stops converter, ignores events
// RQ15 - One shared staging byte for words
// RQ16 - Word low byte at base, high next
// RQ17 - Samples saturate to 0x3FF and 0x000
// RQ18 - Accumulated result never above 0xFFC0
// RQ19 - Window applied to accumulated total only
// RQ20 - Thresholds at 0x12 and 0x14
// RQ21 - Accumulation codes 0-6 give 1 to 64
// RQ22 - Low read stages high byte coherently
// RQ23 - Result low read clears both flags
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.svh"
module adc_window_and_result_control #(
	parameter int CONV_DIV = `CONV_CLK_DIV,
	parameter int CONV_CYC = `CONV_BIT_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic [4:0]  addr,
	input  wire logic [7:0]  wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output var  logic [7:0]  rd_data,
	input  wire logic        start_event,
	input  wire logic        debug_halted,
	input  wire logic [11:0] analog_level,
	output var  logic [4:0]  active_input,
	output var  logic        input_connect,
	output var  logic        sampling,
	output var  logic        irq_window,
	output var  logic        irq_result
);

	localparam logic [4:0] RES_HI  = 5'(`OFS_RESULT + `HI_BYTE_STEP);
	localparam logic [4:0] WLO_HI  = 5'(`OFS_WIN_LOW + `HI_BYTE_STEP);
	localparam logic [4:0] WHI_HI  = 5'(`OFS_WIN_HIGH + `HI_BYTE_STEP);

	logic [2:0]                    accum_q;
	logic [2:0]                    win_mode_q;
	logic [4:0]                    sample_len_q;
	logic [4:0]                    input_sel_q;
	logic                          event_en_q;
	logic [1:0]                    irq_en_q;
	logic                          run_halted_q;
	logic [7:0]                    staging_q;
	logic [15:0]                   result_q;
	logic [15:0]                   win_low_q;
	logic [15:0]                   win_high_q;
	logic                          win_flag_q;
	logic                          res_flag_q;
	logic                          busy_q;
	logic [11:0]                   level_meta_q;
	logic [11:0]                   level_sync_q;
	logic [15:0]                   acc_q;
	logic [6:0]                    cnt_q;
	logic [2:0]                    accum_lat_q;
	logic                          seq_start_q;
	logic                          seq_done;
	logic                          halted;
	logic                          sw_start;
	logic                          ev_start;
	logic                          start_req;
	logic                          last_sample;
	logic                          conv_finish;
	logic [15:0]                   acc_d;
	logic                          win_match;
	logic                          res_lo_read;
	logic                          flag_write;
	logic [7:0]                    rd_data_d;
	adc_types_pkg::conv_state_type state_q;

	// ==========================================================
	// Helper functions
	function automatic logic [9:0] saturate(input logic [11:0] lvl);
		if (lvl[11]) begin
			saturate = `SAMPLE_MIN;
		end else if (lvl[10]) begin
			saturate = `SAMPLE_MAX;
		end else begin
			saturate = lvl[9:0];
		end
	endfunction : saturate

	function automatic logic [6:0] samples(input logic [2:0] code);
		if (code == `ACC_CODE_RSVD) begin
			samples = 7'h01;
		end else begin
			samples = 7'(7'h01 << code);
		end
	endfunction : samples

	function automatic logic sel_valid(input logic [4:0] sel);
		sel_valid = (sel <= `SEL_LAST_PIN) || (sel == `SEL_INT_REF) ||
		            (sel == `SEL_GROUND);
	endfunction : sel_valid

	// ==========================================================
	// Start and halt decisions
	assign halted      = debug_halted && !run_halted_q;             // [RQ14]
	assign sw_start    = wr_en && addr == `OFS_COMMAND &&
	                     wr_data[`BIT_CMD_START];                   // [RQ6]
	assign ev_start    = event_en_q && start_event && !halted;      // [RQ8] [RQ14]
	assign start_req   = !busy_q && (sw_start || ev_start);
	assign last_sample = (cnt_q == 7'(samples(accum_lat_q) - 7'h01)); // [RQ21]
	assign conv_finish = seq_done && last_sample;
	assign res_lo_read = rd_en && addr == `OFS_RESULT;              // [RQ23]
	assign flag_write  = wr_en && addr == `OFS_IRQ_FLAGS;

	// ==========================================================
	// Analog level synchroniser
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			level_meta_q <= 12'h000;
			level_sync_q <= 12'h000;
		end else begin
			level_meta_q <= analog_level;
			level_sync_q <= level_meta_q;
		end
	end

	// ==========================================================
	// Accumulation with ceiling
	always_comb begin
		acc_d = 16'(acc_q + {6'h00, saturate(level_sync_q)}); // [RQ17]
		if (acc_d > `ACC_MAX || acc_d < acc_q) begin
			acc_d = `ACC_MAX;                                 // [RQ18]
		end
	end

	window_check u_window (
		.mode  (win_mode_q),
		.value (acc_d),
		.low   (win_low_q),
		.high  (win_high_q),
		.match (win_match)
	); // [RQ19]

	sample_sequencer #(
		.DIV      (CONV_DIV),
		.CONV_CYC (CONV_CYC)
	) u_seq (
		.ref_clk    (ref_clk),
		.srst       (srst),
		.start      (seq_start_q),
		.stall      (halted),
		.sample_len (sample_len_q),
		.sampling   (sampling),
		.done       (seq_done)
	); // [RQ3] [RQ14]

	// ==========================================================
	// Conversion control
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q       <= adc_types_pkg::CONV_IDLE;
			busy_q        <= 1'b0;
			seq_start_q   <= 1'b0;
			cnt_q         <= 7'h00;
			acc_q         <= `RST_WORD;
			accum_lat_q   <= 3'h0;
			active_input  <= 5'h00;
			input_connect <= 1'b0;
		end else begin
			seq_start_q <= 1'b0;
			case (state_q)
				adc_types_pkg::CONV_IDLE: begin
					if (start_req) begin
						state_q       <= adc_types_pkg::CONV_RUN;
						busy_q        <= 1'b1;              // [RQ7]
						seq_start_q   <= 1'b1;
						cnt_q         <= 7'h00;
						acc_q         <= `RST_WORD;
						accum_lat_q   <= accum_q;
						active_input  <= input_sel_q;       // [RQ5]
						input_connect <= sel_valid(input_sel_q); // [RQ4]
					end
				end
				adc_types_pkg::CONV_RUN: begin
					if (conv_finish) begin
						state_q <= adc_types_pkg::CONV_IDLE;
						busy_q  <= 1'b0;                    // [RQ7]
					end else if (seq_done) begin
						acc_q       <= acc_d;
						cnt_q       <= 7'(cnt_q + 7'h01);
						seq_start_q <= 1'b1;
					end
				end
				default: state_q <= adc_types_pkg::CONV_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			result_q <= `RST_WORD;
		end else if (conv_finish) begin
			result_q <= acc_d;                              // [RQ12]
		end
	end

	// ==========================================================
	// Flags, set wins over clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			win_flag_q <= 1'b0;
			res_flag_q <= 1'b0;
		end else begin
			if (conv_finish) begin
				res_flag_q <= 1'b1;                                 // [RQ12]
			end else if (res_lo_read ||
			             (flag_write && wr_data[`BIT_IRQ_RESULT])) begin
				res_flag_q <= 1'b0;                                 // [RQ13]
			end
			if (conv_finish && win_match) begin
				win_flag_q <= 1'b1;                                 // [RQ10]
			end else if (res_lo_read ||
			             (flag_write && wr_data[`BIT_IRQ_WINDOW])) begin
				win_flag_q <= 1'b0;                                 // [RQ11]
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_window <= 1'b0;
			irq_result <= 1'b0;
		end else begin
			irq_window <= win_flag_q && irq_en_q[`BIT_IRQ_WINDOW]; // [RQ9]
			irq_result <= res_flag_q && irq_en_q[`BIT_IRQ_RESULT]; // [RQ9]
		end
	end

	// ==========================================================
	// Control register writes
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			accum_q      <= 3'h0;
			win_mode_q   <= 3'h0;
			sample_len_q <= 5'h00;
			input_sel_q  <= 5'h00;
			event_en_q   <= 1'b0;
			irq_en_q     <= 2'h0;
			run_halted_q <= 1'b0;
		end else if (wr_en) begin
			if (addr == `OFS_ACCUM_CTRL) begin
				accum_q <= wr_data[2:0];                    // [RQ21]
			end else if (addr == `OFS_WIN_MODE) begin
				win_mode_q <= wr_data[2:0];                 // [RQ1]
			end else if (addr == `OFS_SAMPLE_LEN) begin
				sample_len_q <= wr_data[4:0];               // [RQ3]
			end else if (addr == `OFS_INPUT_SEL) begin
				input_sel_q <= wr_data[4:0];                // [RQ5]
			end else if (addr == `OFS_EVENT_CTRL) begin
				event_en_q <= wr_data[`BIT_EVENT_EN];       // [RQ8]
			end else if (addr == `OFS_IRQ_EN) begin
				irq_en_q <= wr_data[1:0];                   // [RQ9]
			end else if (addr == `OFS_DEBUG_CTRL) begin
				run_halted_q <= wr_data[`BIT_RUN_HALTED];   // [RQ14]
			end
		end
	end

	// ==========================================================
	// Word registers and staging byte
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			staging_q  <= `RST_BYTE;
			win_low_q  <= `RST_WORD;
			win_high_q <= `RST_WORD;
		end else if (wr_en) begin
			if (addr == `OFS_STAGING || addr == `OFS_WIN_LOW ||
			    addr == `OFS_WIN_HIGH) begin
				staging_q <= wr_data;                       // [RQ15]
			end else if (addr == WLO_HI) begin
				win_low_q <= {wr_data, staging_q};          // [RQ16] [RQ20]
			end else if (addr == WHI_HI) begin
				win_high_q <= {wr_data, staging_q};         // [RQ16] [RQ20]
			end
		end else if (rd_en) begin
			if (addr == `OFS_RESULT) begin
				staging_q <= result_q[15:8];                // [RQ22]
			end else if (addr == `OFS_WIN_LOW) begin
				staging_q <= win_low_q[15:8];               // [RQ22]
			end else if (addr == `OFS_WIN_HIGH) begin
				staging_q <= win_high_q[15:8];              // [RQ22]
			end
		end
	end

	// ==========================================================
	// Read data
	always_comb begin
		rd_data_d = 8'h00;
		if (addr == `OFS_ACCUM_CTRL) begin
			rd_data_d = {5'h00, accum_q};
		end else if (addr == `OFS_WIN_MODE) begin
			rd_data_d = {5'h00, win_mode_q};
		end else if (addr == `OFS_SAMPLE_LEN) begin
			rd_data_d = {3'h0, sample_len_q};
		end else if (addr == `OFS_INPUT_SEL) begin
			rd_data_d = {3'h0, input_sel_q};
		end else if (addr == `OFS_COMMAND) begin
			rd_data_d = {7'h00, busy_q};                    // [RQ7]
		end else if (addr == `OFS_EVENT_CTRL) begin
			rd_data_d = {7'h00, event_en_q};
		end else if (addr == `OFS_IRQ_EN) begin
			rd_data_d = {6'h00, irq_en_q};
		end else if (addr == `OFS_IRQ_FLAGS) begin
			rd_data_d = {6'h00, win_flag_q, res_flag_q};
		end else if (addr == `OFS_DEBUG_CTRL) begin
			rd_data_d = {7'h00, run_halted_q};
		end else if (addr == `OFS_STAGING) begin
			rd_data_d = staging_q;                          // [RQ15]
		end else if (addr == `OFS_RESULT) begin
			rd_data_d = result_q[7:0];                      // [RQ16]
		end else if (addr == `OFS_WIN_LOW) begin
			rd_data_d = win_low_q[7:0];
		end else if (addr == `OFS_WIN_HIGH) begin
			rd_data_d = win_high_q[7:0];
		end else if (addr == RES_HI || addr == WLO_HI || addr == WHI_HI) begin
			rd_data_d = staging_q;                          // [RQ22]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= rd_en ? rd_data_d : 8'h00;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	property p_cmd_reads_busy;
		rd_en && addr == `OFS_COMMAND |=> rd_data[0] == $past(busy_q);
	endproperty
	a_cmd_reads_busy: assert property (p_cmd_reads_busy) // [RQ7]
		else $error("command bit does not show busy");

	property p_sw_start;
		sw_start && !busy_q |=> busy_q && seq_start_q;
	endproperty
	a_sw_start: assert property (p_sw_start) // [RQ6]
		else $error("software start not taken");

	property p_event_start;
		!busy_q && event_en_q && start_event && !halted |=> busy_q;
	endproperty
	a_event_start: assert property (p_event_start) // [RQ8]
		else $error("start event not taken");

	property p_halt_ignores;
		!busy_q && halted && !sw_start |=> !busy_q;
	endproperty
	a_halt_ignores: assert property (p_halt_ignores) // [RQ14]
		else $error("event taken while halted");

	property p_finish_flags;
		conv_finish |=> res_flag_q && !busy_q && result_q == $past(acc_d);
	endproperty
	a_finish_flags: assert property (p_finish_flags) // [RQ12]
		else $error("finish did not post result");

	property p_read_clears;
		res_lo_read && !conv_finish |=> !res_flag_q && !win_flag_q;
	endproperty
	a_read_clears: assert property (p_read_clears) // [RQ13] [RQ23]
		else $error("result read left a flag set");

	property p_zero_write_keeps;
		flag_write && wr_data[1:0] == 2'h0 && !rd_en &&
		!conv_finish |=>
			$stable(win_flag_q) && $stable(res_flag_q);
	endproperty
	a_zero_write_keeps: assert property (p_zero_write_keeps) // [RQ11]
		else $error("zero write changed a flag");

	property p_irq_gate;
		##1 irq_window == $past(win_flag_q && irq_en_q[1]) &&
		irq_result == $past(res_flag_q && irq_en_q[0]);
	endproperty
	a_irq_gate: assert property (p_irq_gate) // [RQ9]
		else $error("interrupt not gated by enable");

	property p_acc_ceiling;
		result_q <= `ACC_MAX;
	endproperty
	a_acc_ceiling: assert property (p_acc_ceiling) // [RQ18]
		else $error("result above ceiling");

	property p_sel_held;
		busy_q && $past(busy_q) |-> $stable(active_input);
	endproperty
	a_sel_held: assert property (p_sel_held) // [RQ5]
		else $error("input changed mid conversion");

endmodule : adc_window_and_result_control
`default_nettype wire

/* File: core/adc_consts.svh */
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// ==========================================================
// Register offsets
`define OFS_ACCUM_CTRL   5'h01
`define OFS_WIN_MODE     5'h04
`define OFS_SAMPLE_LEN   5'h05
`define OFS_INPUT_SEL    5'h06
`define OFS_COMMAND      5'h08
`define OFS_EVENT_CTRL   5'h09
`define OFS_IRQ_EN       5'h0A
`define OFS_IRQ_FLAGS    5'h0B
`define OFS_DEBUG_CTRL   5'h0C
`define OFS_STAGING      5'h0D
`define OFS_RESULT       5'h10
`define OFS_WIN_LOW      5'h12
`define OFS_WIN_HIGH     5'h14
`define HI_BYTE_STEP     5'h01

// ==========================================================
// Field positions
`define BIT_CMD_START    0
`define BIT_EVENT_EN     0
`define BIT_RUN_HALTED   0
`define BIT_IRQ_RESULT   0
`define BIT_IRQ_WINDOW   1

// ==========================================================
// Reset values and limits
`define RST_BYTE         8'h00
`define RST_WORD         16'h0000
`define SAMPLE_MAX       10'h3FF
`define SAMPLE_MIN       10'h000
`define ACC_MAX          16'hFFC0
`define ACC_CODE_RSVD    3'h7
`define SEL_LAST_PIN     5'h0B
`define SEL_INT_REF      5'h1D
`define SEL_GROUND       5'h1F

// ==========================================================
// Timing counts
`define BASE_SAMPLE_CYC  6'h02
`define CONV_BIT_CYC     10
`define CONV_CLK_DIV     2

`endif

/* File: core/adc_types_pkg.sv */
`default_nettype none
package adc_types_pkg;

	// ======================================================
	// Types
	typedef enum logic [2:0] {
		WIN_NONE    = 3'h0,
		WIN_BELOW   = 3'h1,
		WIN_ABOVE   = 3'h2,
		WIN_INSIDE  = 3'h3,
		WIN_OUTSIDE = 3'h4
	} window_mode_type;

	typedef enum logic [1:0] {CONV_IDLE, CONV_RUN} conv_state_type;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT}
		seq_state_type;

endpackage : adc_types_pkg
`default_nettype wire

/* File: core/window_check.sv */
`timescale 1ns/1ps
`default_nettype none
module window_check (
	input  wire logic [2:0]  mode,
	input  wire logic [15:0] value,
	input  wire logic [15:0] low,
	input  wire logic [15:0] high,
	output var  logic        match
);

	// ======================================================
	// Comparisons
	function automatic logic is_below(input logic [15:0] v,
	                                  input logic [15:0] t);
		is_below = (v < t);
	endfunction : is_below

	function automatic logic is_above(input logic [15:0] v,
	                                  input logic [15:0] t);
		is_above = (v > t);
	endfunction : is_above

	always_comb begin
		case (adc_types_pkg::window_mode_type'(mode))
			adc_types_pkg::WIN_BELOW:   match = is_below(value, low);  // [RQ1] [RQ2]
			adc_types_pkg::WIN_ABOVE:   match = is_above(value, high); // [RQ1]
			adc_types_pkg::WIN_INSIDE:  match = is_above(value, low) &&
			                                    is_below(value, high); // [RQ1]
			adc_types_pkg::WIN_OUTSIDE: match = is_below(value, low) ||
			                                    is_above(value, high); // [RQ1]
			default:                    match = 1'b0;                  // [RQ1]
		endcase
	end

endmodule : window_check
`default_nettype wire

/* File: core/sample_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.svh"
module sample_sequencer #(
	parameter int DIV      = `CONV_CLK_DIV,
	parameter int CONV_CYC = `CONV_BIT_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic       start,
	input  wire logic       stall,
	input  wire logic [4:0] sample_len,
	output var  logic       sampling,
	output var  logic       done
);

	logic [7:0]                   div_q;
	logic                         tick;
	logic [5:0]                   cnt_q;
	logic [5:0]                   sample_last;
	adc_types_pkg::seq_state_type state_q;

	// ======================================================
	// Converter clock divider
	assign tick = !stall && (div_q == 8'(DIV - 1));
	assign sample_last = 6'(`BASE_SAMPLE_CYC + {1'b0, sample_len} - 6'h01);

	always_ff @(posedge ref_clk) begin
		if (srst || state_q == adc_types_pkg::SEQ_IDLE) begin
			div_q <= 8'h00;
		end else if (tick) begin
			div_q <= 8'h00;
		end else if (!stall) begin
			div_q <= 8'(div_q + 8'h01);
		end
	end

	// ======================================================
	// Sampling and conversion phases
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q  <= adc_types_pkg::SEQ_IDLE;
			cnt_q    <= 6'h00;
			sampling <= 1'b0;
			done     <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_q)
				adc_types_pkg::SEQ_IDLE: begin
					if (start) begin
						state_q  <= adc_types_pkg::SEQ_SAMPLE;
						cnt_q    <= 6'h00;
						sampling <= 1'b1;
					end
				end
				adc_types_pkg::SEQ_SAMPLE: begin
					if (tick && cnt_q == sample_last) begin // [RQ3]
						state_q  <= adc_types_pkg::SEQ_CONVERT;
						cnt_q    <= 6'h00;
						sampling <= 1'b0;
					end else if (tick) begin
						cnt_q <= 6'(cnt_q + 6'h01);
					end
				end
				adc_types_pkg::SEQ_CONVERT: begin
					if (tick && cnt_q == 6'(CONV_CYC - 1)) begin
						state_q <= adc_types_pkg::SEQ_IDLE;
						done    <= 1'b1;
					end else if (tick) begin
						cnt_q <= 6'(cnt_q + 6'h01);
					end
				end
				default: state_q <= adc_types_pkg::SEQ_IDLE;
			endcase
		end
	end

endmodule : sample_sequencer
`default_nettype wire

/* File: bench/test_adc_window_and_result_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module test_adc_window_and_result_control;
	// ==========================================================
	// Signals
	logic        ref_clk = 1'h0, srst = 1'h1;
	logic        wr_en = 1'h0, rd_en = 1'h0;
	logic        start_event = 1'h0, debug_halted = 1'h0;
	logic [4:0]  addr = 5'h00;
	logic [7:0]  wr_data = 8'h00;
	logic [11:0] analog_level = 12'h000;
	logic [7:0]  rd_data, rdv;
	logic [4:0]  active_input;
	logic        input_connect, sampling, irq_window, irq_result;
	int          fails = 0, compares = 0, samp_cnt = 0, s0;
	logic [4:0]  ofs [14] = '{5'h05, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0B,
		5'h0C, 5'h0D, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
	logic [15:0] vals [5] = '{16'h0050, 16'h0100, 16'h0150, 16'h0200,
		16'h0250};
	logic [4:0]  sels [6] = '{5'h00, 5'h0B, 5'h0C, 5'h1D, 5'h1E, 5'h1F};
	logic        conn [6] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};

	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (sampling === 1'h1)
			samp_cnt <= samp_cnt + 1;
	end

	adc_window_and_result_control #(.CONV_DIV(2), .CONV_CYC(2)) dut_u (
		.ref_clk(ref_clk), .srst(srst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.start_event(start_event), .debug_halted(debug_halted),
		.analog_level(analog_level), .active_input(active_input),
		.input_connect(input_connect), .sampling(sampling),
		.irq_window(irq_window), .irq_result(irq_result)
	);

	// ==========================================================
	// Bus tasks
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'h1;
		@(posedge ref_clk);
		wr_en <= 1'h0;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge ref_clk);
		rd_en <= 1'h0;
		#1 d = rd_data;
	endtask : rd

	task automatic rchk(input logic [4:0] a, input logic [7:0] e);
		rd(a, rdv);
		`CHK(rdv, e)
	endtask : rchk

	task automatic wait_idle;
		int n = 0;
		rdv = 8'h01;
		while (rdv[0] !== 1'h0 && n < 3000) begin
			rd(5'h08, rdv);
			n++;
		end
		`CHK(rdv, 8'h00)
	endtask : wait_idle

	task automatic conv(input logic [11:0] lvl);
		@(posedge ref_clk);
		analog_level <= lvl;
		repeat (4) @(posedge ref_clk);
		wr(5'h08, 8'h01);
		rchk(5'h08, 8'h01);
		wait_idle();
	endtask : conv

	task automatic res_chk(input logic [15:0] e);
		rchk(5'h10, e[7:0]);
		rchk(5'h11, e[15:8]);
	endtask : res_chk

	task automatic pulse;
		@(posedge ref_clk);
		start_event <= 1'h1;
		@(posedge ref_clk);
		start_event <= 1'h0;
	endtask : pulse

	function automatic logic win_exp(input int m, input logic [15:0] v);
		case (m)
			1: return v < 16'h0100;
			2: return v > 16'h0200;
			3: return v > 16'h0100 && v < 16'h0200;
			4: return v < 16'h0100 || v > 16'h0200;
			default: return 1'h0;
		endcase
	endfunction : win_exp

	task automatic tally_and_finish;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		tally_and_finish();
	end

	// ==========================================================
	// Tests
	initial begin
		int c, m, i;
		repeat (3) @(posedge ref_clk);
		srst <= 1'h0;
		foreach (ofs[k]) rchk(ofs[k], 8'h00);
		rchk(5'h1E, 8'h00);
		wr(5'h10, 8'hAA);
		rchk(5'h10, 8'h00);
		wr(5'h06, 8'hFF);
		rchk(5'h06, 8'h1F);
		wr(5'h05, 8'hFF);
		rchk(5'h05, 8'h1F);
		wr(5'h12, 8'h34);
		wr(5'h13, 8'h12);
		rchk(5'h12, 8'h34);
		rchk(5'h0D, 8'h12);
		rchk(5'h13, 8'h12);
		wr(5'h0D, 8'h5A);
		rchk(5'h15, 8'h5A);
		wr(5'h12, 8'h00);
		wr(5'h13, 8'h01);
		wr(5'h14, 8'h00);
		wr(5'h15, 8'h02);
		rchk(5'h14, 8'h00);
		rchk(5'h15, 8'h02);
		// Sample length and saturation
		wr(5'h05, 8'h00);
		s0 = samp_cnt;
		conv(12'h123);
		`CHK(samp_cnt - s0, 4)
		rchk(5'h0B, 8'h01);
		res_chk(16'h0123);
		rchk(5'h0B, 8'h00);
		wr(5'h05, 8'h03);
		s0 = samp_cnt;
		conv(12'h400);
		`CHK(samp_cnt - s0, 10)
		res_chk(16'h03FF);
		wr(5'h05, 8'h00);
		conv(12'hFFF);
		res_chk(16'h0000);
		// Accumulation counts
		for (c = 0; c < 8; c++) begin
			wr(5'h01, 8'(c));
			conv(12'h3FF);
			res_chk(c == 7 ? 16'h03FF : 16'h03FF << c);
		end
		wr(5'h01, 8'h02);
		wr(5'h04, 8'h03);
		conv(12'h050);
		rchk(5'h0B, 8'h03);
		res_chk(16'h0140);
		wr(5'h01, 8'h00);
		// Window modes
		for (m = 0; m < 6; m++) begin
			wr(5'h04, 8'(m));
			for (i = 0; i < 5; i++) begin
				conv(vals[i][11:0]);
				rchk(5'h0B, {6'h00, win_exp(m, vals[i]), 1'h1});
				res_chk(vals[i]);
			end
		end
		// Flag clearing and interrupts
		wr(5'h04, 8'h04);
		conv(12'h050);
		wr(5'h0B, 8'h00);
		rchk(5'h0B, 8'h03);
		wr(5'h0A, 8'h03);
		repeat (2) @(posedge ref_clk);
		#1 `CHK({irq_window, irq_result}, 2'h3)
		wr(5'h0A, 8'h01);
		repeat (2) @(posedge ref_clk);
		#1 `CHK({irq_window, irq_result}, 2'h1)
		wr(5'h0B, 8'h02);
		rchk(5'h0B, 8'h01);
		wr(5'h0A, 8'h02);
		repeat (2) @(posedge ref_clk);
		#1 `CHK({irq_window, irq_result}, 2'h0)
		wr(5'h0B, 8'h01);
		rchk(5'h0B, 8'h00);
		// Selector latching
		wr(5'h06, 8'h03);
		wr(5'h08, 8'h01);
		wr(5'h06, 8'h1C);
		`CHK(active_input, 5'h03)
		wait_idle();
		conv(12'h000);
		`CHK(active_input, 5'h1C)
		for (i = 0; i < 6; i++) begin
			wr(5'h06, {3'h0, sels[i]});
			conv(12'h000);
			`CHK(input_connect, conn[i])
		end
		// Event start and debug halt
		rd(5'h10, rdv);
		pulse();
		rchk(5'h08, 8'h00);
		wr(5'h09, 8'h01);
		pulse();
		rchk(5'h08, 8'h01);
		wait_idle();
		@(posedge ref_clk);
		debug_halted <= 1'h1;
		pulse();
		rchk(5'h08, 8'h00);
		wr(5'h0C, 8'h01);
		pulse();
		rchk(5'h08, 8'h01);
		wait_idle();
		// Halt freezes a running conversion
		wr(5'h0C, 8'h00);
		wr(5'h08, 8'h01);
		repeat (40) @(posedge ref_clk);
		rchk(5'h08, 8'h01);
		@(posedge ref_clk);
		debug_halted <= 1'h0;
		wait_idle();
		tally_and_finish();
	end
endmodule : test_adc_window_and_result_control
`default_nettype wire
